// ### core/pdccs_regs.svh
// Register offsets, fields, reset values and response codes of the switch control block
`ifndef PDCCS_REGS_SVH
`define PDCCS_REGS_SVH
`define PDCCS_ADDR_W 6
`define PDCCS_CH0_CTRL 6'h00
`define PDCCS_CH1_CTRL 6'h04
`define PDCCS_STATUS 6'h08
`define PDCCS_IRQ_STAT 6'h0c
`define PDCCS_IRQ_MASK 6'h10
`define PDCCS_PORT_CFG 6'h14
`define PDCCS_F_HS_EN 0
`define PDCCS_F_LS_GATE 1
`define PDCCS_F_SUPPLY 2
`define PDCCS_F_PULLDN 3
`define PDCCS_F_AUX_PATH 4
`define PDCCS_F_AUX_OE 5
`define PDCCS_F_AUX_GATE 6
`define PDCCS_CTRL_RST 7'h38
`define PDCCS_CFG_RST 2'h1
`define PDCCS_RESP_OKAY 2'h0
`define PDCCS_RESP_SLVERR 2'h2
`endif

// ### core/pdccs_pkg.sv
// Types for the switch control block
package pdccs_pkg;
	typedef struct packed {
		logic aux_gate_to_primary;
		logic aux_output_enable;
		logic aux_path_enable;
		logic sink_pulldown_enable;
		logic connector_supply_source_enable;
		logic primary_low_side_gate;
		logic primary_high_side_enable;
	} pdccs_ctrl_s;
	typedef enum logic [2:0] {
		PDCCS_P_ISOLATE = 3'b000,
		PDCCS_P_DRIVE_LOW = 3'b001,
		PDCCS_P_LEAK_OFF = 3'b010,
		PDCCS_P_PASS = 3'b011
	} pdccs_pmode_e;
	typedef enum logic [1:0] {
		PDCCS_A_ISOLATE = 2'b00,
		PDCCS_A_TO_AUX_LOW = 2'b01,
		PDCCS_A_TO_PRIMARY = 2'b10,
		PDCCS_A_DRIVE_LOW = 2'b11
	} pdccs_amode_e;
	typedef struct packed {
		logic high_side_low_oe;
		logic join_primary;
		logic supply_on;
		logic rd_on;
		logic aux_low_oe;
		logic aux_to_low_pin;
		logic aux_to_primary;
	} pdccs_sw_s;
endpackage : pdccs_pkg

// ### core/pdccs_top.sv
// Switch control decoding for two Type-C signal channels with AXI4-Lite registers
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pdccs_regs.svh"
module pdccs_top import pdccs_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite write
	input wire logic [`PDCCS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [`PDCCS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog sense inputs
	input wire logic [1:0] primary_compare_input,
	input wire logic [1:0] pulldown_ground_pin_grounded,
	// Switch controls, one per channel
	output pdccs_sw_s sw_ch0,
	output pdccs_sw_s sw_ch1,
	// Serial pin controls and interrupt
	output logic scl_irq_oe,
	output logic sda_pullup_en,
	output logic irq
);
	pdccs_ctrl_s ctrl_q [2];
	logic [1:0] cfg_q;
	logic [3:0] stat_q;
	logic [3:0] mask_q;
	logic [1:0] cmp_q;
	logic [1:0] gnd_q;
	logic armed_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [`PDCCS_ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic [3:0] events;
	logic [3:0] w1c;

	function automatic pdccs_pmode_e primary_mode(input pdccs_ctrl_s c);
		primary_mode = pdccs_pmode_e'({1'b0, c.primary_low_side_gate,
			c.primary_high_side_enable});
	endfunction : primary_mode

	function automatic pdccs_sw_s decode(input pdccs_ctrl_s c, input logic gnd);
		pdccs_sw_s s;
		pdccs_amode_e am;
		s = '0;
		am = PDCCS_A_ISOLATE;
		unique case (primary_mode(c))
			PDCCS_P_ISOLATE: s.join_primary = 1'b0;
			PDCCS_P_DRIVE_LOW: s.high_side_low_oe = 1'b1;
			PDCCS_P_PASS: s.join_primary = 1'b1;
			PDCCS_P_LEAK_OFF: s.join_primary = 1'b0;
			default: s.join_primary = 1'b0;
		endcase
		s.supply_on = c.connector_supply_source_enable;
		s.rd_on = c.sink_pulldown_enable & gnd;
		if (c.aux_output_enable) begin
			if (c.aux_path_enable && c.aux_gate_to_primary) begin
				am = PDCCS_A_TO_PRIMARY;
			end else if (c.aux_path_enable) begin
				am = PDCCS_A_TO_AUX_LOW;
			end else if (!c.aux_gate_to_primary) begin
				am = PDCCS_A_DRIVE_LOW;
			end
		end
		unique case (am)
			PDCCS_A_ISOLATE: s.aux_to_low_pin = 1'b0;
			PDCCS_A_TO_AUX_LOW: s.aux_to_low_pin = 1'b1;
			PDCCS_A_TO_PRIMARY: s.aux_to_primary = 1'b1;
			PDCCS_A_DRIVE_LOW: s.aux_low_oe = 1'b1;
		endcase
		decode = s;
	endfunction : decode

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	assign do_write = clk_en && aw_hold_q && w_hold_q && !s_axi_bvalid;

	// Write channel capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PDCCS_RESP_OKAY;
		end else if (clk_en) begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				unique case (awaddr_q)
					`PDCCS_CH0_CTRL, `PDCCS_CH1_CTRL, `PDCCS_IRQ_STAT,
					`PDCCS_IRQ_MASK, `PDCCS_PORT_CFG, `PDCCS_STATUS:
						s_axi_bresp <= `PDCCS_RESP_OKAY;
					default: s_axi_bresp <= `PDCCS_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control registers per channel, interrupt mask and port config
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q[0] <= `PDCCS_CTRL_RST;
			ctrl_q[1] <= `PDCCS_CTRL_RST;
			cfg_q <= `PDCCS_CFG_RST;
			mask_q <= '0;
		end else if (do_write) begin
			unique case (awaddr_q)
				`PDCCS_CH0_CTRL:
					ctrl_q[0] <= pdccs_ctrl_s'(7'(merge(32'(ctrl_q[0]), wdata_q, wstrb_q)));
				`PDCCS_CH1_CTRL:
					ctrl_q[1] <= pdccs_ctrl_s'(7'(merge(32'(ctrl_q[1]), wdata_q, wstrb_q)));
				`PDCCS_IRQ_MASK: mask_q <= 4'(merge(32'(mask_q), wdata_q, wstrb_q));
				`PDCCS_PORT_CFG: cfg_q <= 2'(merge(32'(cfg_q), wdata_q, wstrb_q));
				default: mask_q <= mask_q;
			endcase
		end
	end

	// Sense sampling and sticky events, set beats clear
	// No events until the samples hold real pin levels
	assign events = armed_q ? {gnd_q ^ pulldown_ground_pin_grounded,
		cmp_q ^ primary_compare_input} : 4'h0;
	assign w1c = (do_write && awaddr_q == `PDCCS_IRQ_STAT && wstrb_q[0]) ? wdata_q[3:0] : 4'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_q <= '0;
			gnd_q <= '0;
			stat_q <= '0;
			armed_q <= 1'b0;
		end else if (clk_en) begin
			armed_q <= 1'b1;
			cmp_q <= primary_compare_input;
			gnd_q <= pulldown_ground_pin_grounded;
			stat_q <= (stat_q & ~w1c) | events;
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `PDCCS_RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `PDCCS_RESP_OKAY;
				unique case (s_axi_araddr)
					`PDCCS_CH0_CTRL: s_axi_rdata <= 32'(ctrl_q[0]);
					`PDCCS_CH1_CTRL: s_axi_rdata <= 32'(ctrl_q[1]);
					`PDCCS_STATUS: s_axi_rdata <= {28'h0, gnd_q, cmp_q};
					`PDCCS_IRQ_STAT: s_axi_rdata <= {28'h0, stat_q};
					`PDCCS_IRQ_MASK: s_axi_rdata <= {28'h0, mask_q};
					`PDCCS_PORT_CFG: s_axi_rdata <= {30'h0, cfg_q};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `PDCCS_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Switch and pin outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_ch0 <= '0;
			sw_ch1 <= '0;
			scl_irq_oe <= 1'b0;
			sda_pullup_en <= 1'b0;
			irq <= 1'b0;
		end else if (clk_en) begin
			sw_ch0 <= decode(ctrl_q[0], pulldown_ground_pin_grounded[0]);
			sw_ch1 <= decode(ctrl_q[1], pulldown_ground_pin_grounded[1]);
			irq <= |(stat_q & mask_q);
			scl_irq_oe <= cfg_q[1] && |(stat_q & mask_q);
			sda_pullup_en <= cfg_q[0];
		end
	end
endmodule : pdccs_top
`default_nettype wire

// ### bench/pdccs_top_asserts.sv
// Checker for the switch control block
`timescale 1ns/1ns
`default_nettype none
module pdccs_top_asserts import pdccs_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Switch side
	input wire logic [1:0] pulldown_ground_pin_grounded,
	input wire pdccs_sw_s sw_ch0,
	input wire pdccs_sw_s sw_ch1
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	hs_excl_a: assert property (!(sw_ch0.join_primary && sw_ch0.high_side_low_oe))
		else $error("primary drive and join together");
	aux_excl_a: assert property ($onehot0({sw_ch1.aux_low_oe, sw_ch1.aux_to_low_pin,
		sw_ch1.aux_to_primary}))
		else $error("aux paths overlap");
	rd_ground_a: assert property (sw_ch0.rd_on |-> $past(pulldown_ground_pin_grounded[0]))
		else $error("pull-down with floating ground");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read answer dropped");
	ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready held");
	b_answer_a: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
endmodule : pdccs_top_asserts
bind pdccs_top pdccs_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .pulldown_ground_pin_grounded(pulldown_ground_pin_grounded),
	.sw_ch0(sw_ch0), .sw_ch1(sw_ch1));
`default_nettype wire

// ### bench/pdccs_far_end.sv
// Connector side model feeding the comparators
`timescale 1ns/1ns
`default_nettype none
module pdccs_far_end import pdccs_pkg::*; (
	// Switch state
	input wire pdccs_sw_s sw_ch0,
	input wire pdccs_sw_s sw_ch1,
	// Connector line levels
	input wire logic [1:0] cc_line_high,
	// Comparator results
	output logic [1:0] primary_compare_input
);
	// Comparator sees the line only through the joined path
	assign primary_compare_input = {sw_ch1.join_primary & cc_line_high[1],
		sw_ch0.join_primary & cc_line_high[0]};
endmodule : pdccs_far_end
`default_nettype wire

// ### bench/pdccs_top_tb.sv
// Testbench of the switch control block
`timescale 1ns/1ns
`default_nettype none
`include "pdccs_regs.svh"
module pdccs_top_tb import pdccs_pkg::*;;
	logic aclk = 0, aresetn = 0, clk_en = 1;
	logic [5:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq, scl_oe, sda_pu;
	logic [31:0] wdata = '0, rdata, d;
	logic [1:0] bresp, rresp, cmp, grounded = 2'b01, cc_hi = 2'b00;
	pdccs_sw_s sw0, sw1;
	int failures = 0, comparisons = 0;
	always #5 aclk = ~aclk;
	pdccs_top dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.primary_compare_input(cmp), .pulldown_ground_pin_grounded(grounded), .sw_ch0(sw0),
		.sw_ch1(sw1), .scl_irq_oe(scl_oe), .sda_pullup_en(sda_pu), .irq(irq));
	pdccs_far_end u_far (.sw_ch0(sw0), .sw_ch1(sw1), .cc_line_high(cc_hi),
		.primary_compare_input(cmp));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		bready <= 0;
		chk(32'(bresp), 32'(er));
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		rready <= 0;
		d = rdata;
		chk(32'(rresp), 32'(er));
	endtask : rd
	function automatic pdccs_sw_s exp_sw(input logic [6:0] c, input logic g);
		exp_sw.high_side_low_oe = c[0] & ~c[1];
		exp_sw.join_primary = c[0] & c[1];
		exp_sw.supply_on = c[2];
		exp_sw.rd_on = c[3] & g;
		exp_sw.aux_low_oe = c[5] & ~c[6] & ~c[4];
		exp_sw.aux_to_low_pin = c[5] & ~c[6] & c[4];
		exp_sw.aux_to_primary = c[5] & c[6] & c[4];
	endfunction : exp_sw
	task automatic t_reset;
		repeat (2) @(posedge aclk);
		chk(32'({sw1, sw0}), 32'({exp_sw(7'h38, 1'b0), exp_sw(7'h38, 1'b1)}));
		rd(`PDCCS_CH1_CTRL, 2'h0);
		chk(d, 32'h38);
		chk(32'(sda_pu), 32'h1);
	endtask : t_reset
	task automatic t_modes;
		logic [6:0] tbl [10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h08, 7'h30, 7'h20,
			7'h60, 7'h70};
		foreach (tbl[i]) begin
			wr(`PDCCS_CH0_CTRL, {25'h0, tbl[i]}, 2'h0);
			wr(`PDCCS_CH1_CTRL, {25'h0, ~tbl[i]}, 2'h0);
			repeat (2) @(posedge aclk);
			chk(32'({sw1, sw0}), 32'({exp_sw(~tbl[i], 1'b0), exp_sw(tbl[i], 1'b1)}));
		end
	endtask : t_modes
	task automatic t_bus;
		wr(6'h18, 32'h1, 2'h2);
		rd(6'h18, 2'h2);
		wr(`PDCCS_STATUS, 32'hf, 2'h0);
		rd(`PDCCS_STATUS, 2'h0);
		chk(d, 32'h4);
	endtask : t_bus
	task automatic t_irq;
		wr(`PDCCS_CH0_CTRL, 32'h3, 2'h0);
		wr(`PDCCS_IRQ_STAT, 32'hf, 2'h0);
		wr(`PDCCS_IRQ_MASK, 32'h1, 2'h0);
		wr(`PDCCS_PORT_CFG, 32'h2, 2'h0);
		cc_hi <= 2'b01;
		repeat (4) @(posedge aclk);
		chk(32'({irq, scl_oe, sda_pu}), 32'h6);
		wr(`PDCCS_IRQ_STAT, 32'h1, 2'h0);
		repeat (2) @(posedge aclk);
		chk(32'({irq, scl_oe}), 32'h0);
		wr(`PDCCS_IRQ_MASK, 32'h0, 2'h0);
		cc_hi <= 2'b00;
		repeat (4) @(posedge aclk);
		chk(32'(irq), 32'h0);
		rd(`PDCCS_IRQ_STAT, 2'h0);
		chk(d, 32'h1);
	endtask : t_irq
	task automatic wrap_up;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		failures++;
		wrap_up;
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_modes;
		t_bus;
		t_irq;
		wrap_up;
	end
endmodule : pdccs_top_tb
`default_nettype wire
